// ### logic/rtc_interval_alarm.sv
// Purpose: real time clock with hundredths/second/minute/hour counters and interval alarm
// Assumes: sfr bus on ref_clk; crystal sampled in as a plain pin
// Notes: resetn is power-on reset only; watchdog and pin resets must not reach it
`include "rtia_regs.svh"
`default_nettype none
module rtc_interval_alarm
  import rtia_pkg::*;
#(
  parameter int XTAL_PER_TICK = `RTIA_XTAL_PER_TICK
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic xtal_in,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic clock_irq,
  output logic adc_strobe_enable,
  output logic [7:0] nominal_trim_out,
  output logic [7:0] thermal_trim_out
);
  // divider is 16 bits, so larger tick ratios cannot be served
  if (XTAL_PER_TICK < 1 || XTAL_PER_TICK > 65536)
  begin : g_div_check
    $error("crystal edges per tick out of range");
  end

  // power-on config value, one source for every bit's reset
  localparam logic [7:0] CFG_RST = `RTIA_CONFIG_RESET;

  function automatic logic [7:0] wrap_inc(input logic [7:0] v, input logic [7:0] maxv);
    wrap_inc = (v == maxv) ? 8'h00 : v + 8'h01;
  endfunction

  logic xtal_rise;
  logic [15:0] div_ff;
  logic [7:0] hund_ff;
  logic [7:0] sec_ff;
  logic [7:0] min_ff;
  logic [7:0] hour_ff;
  logic [7:0] ival_ff;
  logic [7:0] icnt_ff;
  logic midnight_ff;
  logic day_fmt_ff;
  logic [1:0] tbase_ff;
  logic one_shot_ff;
  logic alarm_ff;
  logic ien_ff;
  logic run_ff;
  rtia_iv_state_type iv_ff;
  logic [7:0] trim_rd;

  // crystal edges counted on ref_clk; low-power modes have no input here
  rtia_sync3 u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(xtal_in),
    .rise_pulse(xtal_rise)
  );

  wire wr_cfg = sfr_wr && (sfr_addr == `RTIA_CLOCK_CONFIG_ADDR);
  wire wr_hund = sfr_wr && (sfr_addr == `RTIA_HUNDREDTHS_ADDR);
  wire wr_sec = sfr_wr && (sfr_addr == `RTIA_SECONDS_ADDR);
  wire wr_min = sfr_wr && (sfr_addr == `RTIA_MINUTES_ADDR);
  wire wr_hour = sfr_wr && (sfr_addr == `RTIA_HOURS_ADDR);
  wire wr_ival = sfr_wr && (sfr_addr == `RTIA_INTERVAL_ADDR);
  wire sel_nom = (sfr_addr == `RTIA_NOMINAL_TRIM_ADDR);
  wire sel_thm = (sfr_addr == `RTIA_THERMAL_TRIM_ADDR);
  wire wr_trim = sfr_wr && (sel_nom || sel_thm);

  rtia_trim_regs #(.DW(8)) u_trim (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wr_en(wr_trim),
    .sel_thermal(sel_thm),
    .wr_data(sfr_wdata),
    .rd_data(trim_rd),
    .nominal_out(nominal_trim_out),
    .thermal_out(thermal_trim_out)
  );

  // time chain
  wire [15:0] div_max = 16'(XTAL_PER_TICK - 1);
  wire tick = run_ff && xtal_rise && (div_ff == div_max);
  wire [7:0] hour_max = day_fmt_ff ? `RTIA_HOUR24_MAX : `RTIA_HOUR256_MAX;
  wire hund_wrap = tick && (hund_ff == `RTIA_HUNDREDTHS_MAX);
  wire sec_wrap = hund_wrap && (sec_ff == `RTIA_SIXTY_MAX);
  wire min_wrap = sec_wrap && (min_ff == `RTIA_SIXTY_MAX);
  wire hour_wrap = min_wrap && (hour_ff == hour_max);

  wire [7:0] nxt_hund = !run_ff ? 8'h00 : wr_hund ? sfr_wdata :
                        tick ? wrap_inc(hund_ff, `RTIA_HUNDREDTHS_MAX) : hund_ff;
  wire [7:0] nxt_sec = !run_ff ? 8'h00 : wr_sec ? sfr_wdata :
                       hund_wrap ? wrap_inc(sec_ff, `RTIA_SIXTY_MAX) : sec_ff;
  wire [7:0] nxt_min = !run_ff ? 8'h00 : wr_min ? sfr_wdata :
                       sec_wrap ? wrap_inc(min_ff, `RTIA_SIXTY_MAX) : min_ff;
  wire [7:0] nxt_hour = !run_ff ? 8'h00 : wr_hour ? sfr_wdata :
                        min_wrap ? wrap_inc(hour_ff, hour_max) : hour_ff;
  wire [15:0] nxt_div = !run_ff ? 16'h0000 :
                        xtal_rise ? ((div_ff == div_max) ? 16'h0000 : div_ff + 16'h0001) :
                        div_ff;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_ff <= 16'h0000;
      hund_ff <= 8'h00;
      sec_ff <= 8'h00;
      min_ff <= 8'h00;
      hour_ff <= 8'h00;
    end
    else
    begin
      div_ff <= nxt_div;
      hund_ff <= nxt_hund;
      sec_ff <= nxt_sec;
      min_ff <= nxt_min;
      hour_ff <= nxt_hour;
    end
  end

  // interval timer
  rtia_timebase_type tb_sel;
  assign tb_sel = (tbase_ff == 2'b00) ? RTIA_TB_TICK :
                  (tbase_ff == 2'b01) ? RTIA_TB_SEC :
                  (tbase_ff == 2'b10) ? RTIA_TB_MIN : RTIA_TB_HOUR;
  logic unit_evt;
  always_comb
  begin
    case (tb_sel)
      RTIA_TB_TICK: unit_evt = tick;
      RTIA_TB_SEC: unit_evt = hund_wrap;
      RTIA_TB_MIN: unit_evt = sec_wrap;
      RTIA_TB_HOUR: unit_evt = min_wrap;
      default: unit_evt = 1'b0;
    endcase
  end
  wire iv_on = ien_ff && run_ff;
  wire iv_count = iv_on && (iv_ff == RTIA_IV_RUN) && unit_evt;
  wire [7:0] icnt_inc = icnt_ff + 8'h01;
  wire iv_hit = iv_count && (icnt_inc == ival_ff);

  rtia_iv_state_type nxt_iv;
  always_comb
  begin
    case (iv_ff)
      RTIA_IV_IDLE: nxt_iv = iv_on ? RTIA_IV_RUN : RTIA_IV_IDLE;
      RTIA_IV_RUN: nxt_iv = !iv_on ? RTIA_IV_IDLE :
                            (iv_hit && one_shot_ff) ? RTIA_IV_DONE : RTIA_IV_RUN;
      RTIA_IV_DONE: nxt_iv = !iv_on ? RTIA_IV_IDLE : RTIA_IV_DONE;
      default: nxt_iv = RTIA_IV_IDLE;
    endcase
  end
  wire [7:0] nxt_icnt = !iv_on ? 8'h00 : iv_hit ? 8'h00 :
                        iv_count ? icnt_inc : icnt_ff;

  // config: flags set by hardware win over a software clear
  wire [7:0] nxt_ival = wr_ival ? sfr_wdata : ival_ff;
  wire nxt_midnight = hour_wrap || (wr_cfg ? sfr_wdata[`RTIA_MIDNIGHT_BIT] : midnight_ff);
  wire nxt_alarm = iv_hit || (wr_cfg ? sfr_wdata[`RTIA_ALARM_BIT] : alarm_ff);
  wire nxt_irq = hour_wrap || iv_hit;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      midnight_ff <= CFG_RST[`RTIA_MIDNIGHT_BIT];
      day_fmt_ff <= CFG_RST[`RTIA_DAY_FORMAT_BIT];
      tbase_ff <= CFG_RST[`RTIA_TIMEBASE_HI:`RTIA_TIMEBASE_LO];
      one_shot_ff <= CFG_RST[`RTIA_ONE_SHOT_BIT];
      alarm_ff <= CFG_RST[`RTIA_ALARM_BIT];
      ien_ff <= CFG_RST[`RTIA_INTERVAL_EN_BIT];
      run_ff <= CFG_RST[`RTIA_RUN_EN_BIT];
      ival_ff <= 8'h00;
      icnt_ff <= 8'h00;
      iv_ff <= RTIA_IV_IDLE;
      clock_irq <= 1'b0;
      adc_strobe_enable <= CFG_RST[`RTIA_RUN_EN_BIT];
    end
    else
    begin
      midnight_ff <= nxt_midnight;
      alarm_ff <= nxt_alarm;
      if (wr_cfg)
      begin
        day_fmt_ff <= sfr_wdata[`RTIA_DAY_FORMAT_BIT];
        tbase_ff <= sfr_wdata[`RTIA_TIMEBASE_HI:`RTIA_TIMEBASE_LO];
        one_shot_ff <= sfr_wdata[`RTIA_ONE_SHOT_BIT];
        ien_ff <= sfr_wdata[`RTIA_INTERVAL_EN_BIT];
        run_ff <= sfr_wdata[`RTIA_RUN_EN_BIT];
      end
      ival_ff <= nxt_ival;
      icnt_ff <= nxt_icnt;
      iv_ff <= nxt_iv;
      clock_irq <= nxt_irq;
      adc_strobe_enable <= wr_cfg ? sfr_wdata[`RTIA_RUN_EN_BIT] : run_ff;
    end
  end

  // read path, one cycle after request; unmapped reads return zero
  wire [7:0] cfg_rd = {midnight_ff, day_fmt_ff, tbase_ff, one_shot_ff, alarm_ff, ien_ff, run_ff};
  wire [7:0] rd_mux = (sfr_addr == `RTIA_CLOCK_CONFIG_ADDR) ? cfg_rd :
                      (sfr_addr == `RTIA_HUNDREDTHS_ADDR) ? hund_ff :
                      (sfr_addr == `RTIA_SECONDS_ADDR) ? sec_ff :
                      (sfr_addr == `RTIA_MINUTES_ADDR) ? min_ff :
                      (sfr_addr == `RTIA_HOURS_ADDR) ? hour_ff :
                      (sfr_addr == `RTIA_INTERVAL_ADDR) ? ival_ff : 8'h00;
  logic trim_pend_ff;
  logic [7:0] rd_ff;
  // trim memory answers one cycle later, so trim reads take two cycles
  wire [7:0] nxt_rd = trim_pend_ff ? trim_rd : sfr_rd ? rd_mux : 8'h00;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_ff <= 8'h00;
      trim_pend_ff <= 1'b0;
    end
    else
    begin
      rd_ff <= nxt_rd;
      trim_pend_ff <= sfr_rd && (sel_nom || sel_thm);
    end
  end
  assign sfr_rdata = rd_ff;

  // a software load in the same cycle legally overrides the wrap value
  hour_wrap_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    hour_wrap |=> midnight_ff && clock_irq && (hour_ff == 8'h00 || $past(wr_hour)))
    else $error("hour wrap did not raise midnight");
  midnight_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    midnight_ff && !wr_cfg |=> midnight_ff)
    else $error("midnight flag dropped by itself");
  midnight_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_cfg && !sfr_wdata[`RTIA_MIDNIGHT_BIT] && !hour_wrap |=> !midnight_ff)
    else $error("midnight flag not cleared by software");
  alarm_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    alarm_ff && !wr_cfg |=> alarm_ff)
    else $error("alarm flag dropped by itself");
  alarm_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_cfg && !sfr_wdata[`RTIA_ALARM_BIT] && !iv_hit |=> !alarm_ff)
    else $error("alarm flag not cleared by software");
  iv_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !ien_ff ##1 !ien_ff |-> icnt_ff == 8'h00)
    else $error("interval count not held at zero");
  run_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !run_ff ##1 !run_ff |-> hund_ff == 8'h00 && hour_ff == 8'h00)
    else $error("counters not cleared while disabled");
  div_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !run_ff |=> div_ff == 16'h0000)
    else $error("tick divider ran while disabled");
  div_range_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    div_ff <= div_max)
    else $error("tick divider left range");
  hund_wrap_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    hund_wrap && !wr_hund |=> hund_ff == 8'h00)
    else $error("hundredths did not wrap at 127");
  hund_range_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !wr_hund && hund_ff <= `RTIA_HUNDREDTHS_MAX |=> hund_ff <= `RTIA_HUNDREDTHS_MAX)
    else $error("hundredths left range");
  sec_range_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    hund_wrap && !wr_sec && sec_ff <= `RTIA_SIXTY_MAX |=> sec_ff <= `RTIA_SIXTY_MAX)
    else $error("seconds left range");
  sec_wrap_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    sec_wrap && !wr_sec |=> sec_ff == 8'h00)
    else $error("seconds did not wrap at 59");
  min_wrap_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    min_wrap && !wr_min |=> min_ff == 8'h00)
    else $error("minutes did not wrap at 59");
  hour_day_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    day_fmt_ff && min_wrap && !wr_hour && hour_ff == `RTIA_HOUR24_MAX |=> hour_ff == 8'h00)
    else $error("day format hour did not wrap at 23");
  hour_long_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !day_fmt_ff && min_wrap && !wr_hour && hour_ff == `RTIA_HOUR24_MAX |=> hour_ff == 8'h18)
    else $error("long format hour wrapped at 23");
  hund_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_hund && run_ff |=> hund_ff == $past(sfr_wdata))
    else $error("hundredths write not loaded");
  sec_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_sec && run_ff |=> sec_ff == $past(sfr_wdata))
    else $error("seconds write not loaded");
  min_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_min && run_ff |=> min_ff == $past(sfr_wdata))
    else $error("minutes write not loaded");
  hour_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_hour && run_ff |=> hour_ff == $past(sfr_wdata))
    else $error("hours write not loaded");
  ival_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_ival |=> ival_ff == $past(sfr_wdata))
    else $error("interval value write not loaded");
  trim_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_trim && sel_thm |=> thermal_trim_out == $past(sfr_wdata))
    else $error("thermal trim write not loaded");
  cfg_keep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !wr_cfg |=> $stable(day_fmt_ff) && $stable(run_ff))
    else $error("format or run enable changed without a write");
  strobe_copy_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_cfg |=> adc_strobe_enable == $past(sfr_wdata[`RTIA_RUN_EN_BIT]))
    else $error("strobe enable does not follow run enable");
  iv_rearm_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    iv_hit && !one_shot_ff |=> iv_ff == RTIA_IV_RUN && icnt_ff == 8'h00)
    else $error("repeat interval did not restart");
  one_shot_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    iv_hit && one_shot_ff && !wr_cfg |=> !iv_hit [*2])
    else $error("one-shot alarm repeated");
  alarm_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    iv_hit |=> alarm_ff && clock_irq)
    else $error("interval match missed alarm");
  irq_src_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clock_irq |-> $past(hour_wrap) || $past(iv_hit))
    else $error("interrupt without a wrap or match");
  iv_stop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !iv_on |=> iv_ff == RTIA_IV_IDLE)
    else $error("interval timer kept running while disabled");
  iv_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !run_ff |=> !$rose(alarm_ff) || $past(wr_cfg))
    else $error("interval ran with clock disabled");
  xtal_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    xtal_rise |=> !xtal_rise)
    else $error("crystal edge counted twice");
endmodule // rtc_interval_alarm
`default_nettype wire

// ### logic/rtia_pkg.sv
// Purpose: types shared by the clock block
// Assumes: nothing
// Notes: constants live in rtia_regs.svh
`default_nettype none
package rtia_pkg;
  typedef enum logic [3:0] {
    RTIA_TB_TICK = 4'b0001,
    RTIA_TB_SEC = 4'b0010,
    RTIA_TB_MIN = 4'b0100,
    RTIA_TB_HOUR = 4'b1000
  } rtia_timebase_type;
  typedef enum logic [2:0] {
    RTIA_IV_IDLE = 3'b001,
    RTIA_IV_RUN = 3'b010,
    RTIA_IV_DONE = 3'b100
  } rtia_iv_state_type;
endpackage
`default_nettype wire

// ### logic/rtia_regs.svh
// Purpose: offsets, field positions, reset values and timing counts of the clock block
// Assumes: 8-bit special function register space
// Notes: included by bare name
`ifndef RTIA_REGS_SVH
`define RTIA_REGS_SVH
`define RTIA_CLOCK_CONFIG_ADDR 8'ha1
`define RTIA_HUNDREDTHS_ADDR 8'ha2
`define RTIA_SECONDS_ADDR 8'ha3
`define RTIA_MINUTES_ADDR 8'ha4
`define RTIA_HOURS_ADDR 8'ha5
`define RTIA_INTERVAL_ADDR 8'ha6
`define RTIA_NOMINAL_TRIM_ADDR 8'hf6
`define RTIA_THERMAL_TRIM_ADDR 8'hf7
`define RTIA_MIDNIGHT_BIT 7
`define RTIA_DAY_FORMAT_BIT 6
`define RTIA_TIMEBASE_HI 5
`define RTIA_TIMEBASE_LO 4
`define RTIA_ONE_SHOT_BIT 3
`define RTIA_ALARM_BIT 2
`define RTIA_INTERVAL_EN_BIT 1
`define RTIA_RUN_EN_BIT 0
`define RTIA_CONFIG_RESET 8'h01
`define RTIA_CRYSTAL_HZ 32768
`define RTIA_TICKS_PER_SECOND 128
`define RTIA_XTAL_PER_TICK 256
`define RTIA_HUNDREDTHS_MAX 8'h7f
`define RTIA_SIXTY_MAX 8'h3b
`define RTIA_HOUR24_MAX 8'h17
`define RTIA_HOUR256_MAX 8'hff
`endif

// ### logic/rtia_sync3.sv
// Purpose: three-stage synchroniser with agreement check, rising-edge pulse out
// Assumes: input from a foreign domain
// Notes: stage one is read only by stage two
`default_nettype none
module rtia_sync3
  import rtia_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic rise_pulse
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  wire agree = (s2_ff == s3_ff);
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
      rise_pulse <= 1'b0;
    end
    else
    begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree)
        level_ff <= s3_ff;
      rise_pulse <= agree && s3_ff && !level_ff;
    end
  end
endmodule // rtia_sync3
`default_nettype wire

// ### logic/rtia_trim_regs.sv
// Purpose: holds the nominal and temperature trim words and a registered read port
// Assumes: cleared only at power-on reset
// Notes: values go out to the compensation logic unchanged
`default_nettype none
module rtia_trim_regs
  import rtia_pkg::*;
#(
  parameter int DW = 8
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic sel_thermal,
  input wire logic [DW-1:0] wr_data,
  output logic [DW-1:0] rd_data,
  output logic [DW-1:0] nominal_out,
  output logic [DW-1:0] thermal_out
);
  // refused while the design is elaborated, not at run time
  if (DW < 1)
  begin : g_dw_check
    $error("trim width must be positive");
  end
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      nominal_out <= '0;
      thermal_out <= '0;
      rd_data <= '0;
    end
    else
    begin
      if (wr_en && !sel_thermal)
        nominal_out <= wr_data;
      if (wr_en && sel_thermal)
        thermal_out <= wr_data;
      rd_data <= sel_thermal ? thermal_out : nominal_out;
    end
  end
endmodule // rtia_trim_regs
`default_nettype wire

// ### test/rtc_interval_alarm_tb.sv
// Purpose: self-checking bench for the real time clock and interval alarm block
// Assumes: crystal scaled to 8 ref_clk cycles per period, XTAL_PER_TICK of 2
// Notes: one tick is 2 crystal rises, so 16 ref_clk cycles
`include "rtia_regs.svh"
`default_nettype none
module rtc_interval_alarm_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b1;
  logic xtal_in = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic clock_irq;
  logic adc_strobe_enable;
  logic [7:0] nominal_trim_out;
  logic [7:0] thermal_trim_out;
  int n_mismatch = 0;
  int total_checks = 0;
  localparam int TICK_CYC = 16;

  rtc_interval_alarm #(.XTAL_PER_TICK(2)) u_rtc_interval_alarm (
    .ref_clk(ref_clk), .resetn(resetn), .xtal_in(xtal_in), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .clock_irq(clock_irq),
    .adc_strobe_enable(adc_strobe_enable), .nominal_trim_out(nominal_trim_out),
    .thermal_trim_out(thermal_trim_out)
  );

  always #50 ref_clk = ~ref_clk;
  // crystal toggles on falling clock edges, so tick spacing is exact
  always #400 xtal_in = ~xtal_in;

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge ref_clk);
    #1;
    sfr_wr = 1'b0;
  endtask

  // trim reads answer one cycle later, address held meanwhile
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    #1;
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge ref_clk);
    #1;
    sfr_rd = 1'b0;
    if (a[7:4] == 4'hf)
    begin
      @(posedge ref_clk);
      #1;
    end
    v = sfr_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v & m, exp, "register read");
  endtask

  task automatic count_irq(input int cycles, output int n);
    n = 0;
    repeat (cycles)
    begin
      @(posedge ref_clk);
      #1;
      if (clock_irq === 1'b1)
        n++;
    end
  endtask

  task automatic t_regs;
    rdchk(`RTIA_CLOCK_CONFIG_ADDR, 8'hff, 8'h01);
    chk({7'h0, adc_strobe_enable}, 8'h01, "strobe enable at reset");
    wr(8'ha0, 8'h55);
    rdchk(8'ha0, 8'hff, 8'h00);
    wr(`RTIA_HOURS_ADDR, 8'h12);
    rdchk(`RTIA_HOURS_ADDR, 8'hff, 8'h12);
    wr(`RTIA_INTERVAL_ADDR, 8'h9c);
    rdchk(`RTIA_INTERVAL_ADDR, 8'hff, 8'h9c);
    wr(`RTIA_NOMINAL_TRIM_ADDR, 8'h3c);
    wr(`RTIA_THERMAL_TRIM_ADDR, 8'hc3);
    rdchk(`RTIA_NOMINAL_TRIM_ADDR, 8'hff, 8'h3c);
    rdchk(`RTIA_THERMAL_TRIM_ADDR, 8'hff, 8'hc3);
    chk(nominal_trim_out, 8'h3c, "nominal trim out");
    chk(thermal_trim_out, 8'hc3, "thermal trim out");
  endtask

  // hundredths preset one short of wrap so the wrap lands inside the window
  task automatic t_roll(input logic [7:0] cfg, input logic [7:0] hr, input logic [7:0] exp_hr,
                        input logic mid);
    int n;
    wr(`RTIA_CLOCK_CONFIG_ADDR, cfg);
    wr(`RTIA_HOURS_ADDR, hr);
    wr(`RTIA_MINUTES_ADDR, 8'h3b);
    wr(`RTIA_SECONDS_ADDR, 8'h3b);
    wr(`RTIA_HUNDREDTHS_ADDR, 8'h7e);
    count_irq(60, n);
    chk(8'(n), {7'h0, mid}, "hour wrap interrupt");
    rdchk(`RTIA_HOURS_ADDR, 8'hff, exp_hr);
    rdchk(`RTIA_MINUTES_ADDR, 8'hff, 8'h00);
    rdchk(`RTIA_SECONDS_ADDR, 8'hff, 8'h00);
    rdchk(`RTIA_CLOCK_CONFIG_ADDR, 8'h80, {mid, 7'h0});
    rdchk(`RTIA_CLOCK_CONFIG_ADDR, 8'h80, {mid, 7'h0});
    wr(`RTIA_CLOCK_CONFIG_ADDR, cfg);
    rdchk(`RTIA_CLOCK_CONFIG_ADDR, 8'h80, 8'h00);
  endtask

  task automatic t_repeat;
    int g;
    int k;
    wr(`RTIA_INTERVAL_ADDR, 8'h03);
    wr(`RTIA_CLOCK_CONFIG_ADDR, 8'h03);
    k = 0;
    while (clock_irq !== 1'b1 && k < 200)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    g = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      g++;
    end
    while (clock_irq !== 1'b1 && g < 200);
    chk(8'(g), 8'(3 * TICK_CYC), "repeat interval gap");
    rdchk(`RTIA_CLOCK_CONFIG_ADDR, 8'h04, 8'h04);
  endtask

  task automatic t_oneshot;
    int n;
    wr(`RTIA_CLOCK_CONFIG_ADDR, 8'h01);
    rdchk(`RTIA_CLOCK_CONFIG_ADDR, 8'h04, 8'h00);
    wr(`RTIA_CLOCK_CONFIG_ADDR, 8'h0b);
    count_irq(200, n);
    chk(8'(n), 8'h01, "one-shot alarm count");
    rdchk(`RTIA_CLOCK_CONFIG_ADDR, 8'h04, 8'h04);
  endtask

  // second, minute and hour events are forced by presetting the lower counters to their top
  task automatic t_timebase;
    wr(`RTIA_INTERVAL_ADDR, 8'h01);
    for (int ts = 0; ts < 4; ts++)
    begin
      wr(`RTIA_CLOCK_CONFIG_ADDR, 8'h01);
      wr(`RTIA_MINUTES_ADDR, 8'h00);
      wr(`RTIA_SECONDS_ADDR, 8'h00);
      wr(`RTIA_HUNDREDTHS_ADDR, 8'h00);
      wr(`RTIA_CLOCK_CONFIG_ADDR, {2'b00, 2'(ts), 4'h3});
      repeat (40) @(posedge ref_clk);
      rdchk(`RTIA_CLOCK_CONFIG_ADDR, 8'h04, (ts == 0) ? 8'h04 : 8'h00);
      if (ts >= 3)
        wr(`RTIA_MINUTES_ADDR, 8'h3b);
      if (ts >= 2)
        wr(`RTIA_SECONDS_ADDR, 8'h3b);
      wr(`RTIA_HUNDREDTHS_ADDR, 8'h7f);
      repeat (40) @(posedge ref_clk);
      rdchk(`RTIA_CLOCK_CONFIG_ADDR, 8'h04, 8'h04);
    end
  endtask

  task automatic t_disable;
    wr(`RTIA_CLOCK_CONFIG_ADDR, 8'h00);
    chk({7'h0, adc_strobe_enable}, 8'h00, "strobe enable off");
    rdchk(`RTIA_HUNDREDTHS_ADDR, 8'hff, 8'h00);
    wr(`RTIA_HOURS_ADDR, 8'h05);
    rdchk(`RTIA_HOURS_ADDR, 8'hff, 8'h00);
    wr(`RTIA_CLOCK_CONFIG_ADDR, 8'h01);
    chk({7'h0, adc_strobe_enable}, 8'h01, "strobe enable on");
  endtask

  task automatic t_por;
    wr(`RTIA_HOURS_ADDR, 8'h09);
    wr(`RTIA_CLOCK_CONFIG_ADDR, 8'h41);
    resetn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    rdchk(`RTIA_HOURS_ADDR, 8'hff, 8'h00);
    rdchk(`RTIA_CLOCK_CONFIG_ADDR, 8'hff, 8'h01);
    rdchk(`RTIA_NOMINAL_TRIM_ADDR, 8'hff, 8'h00);
  endtask

  // a declared start value makes no edge, so reset is asserted by an event
  initial
  begin
    #1;
    resetn = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    t_regs;
    t_roll(8'h41, 8'h17, 8'h00, 1'b1);
    t_roll(8'h01, 8'h17, 8'h18, 1'b0);
    t_roll(8'h01, 8'hff, 8'h00, 1'b1);
    t_repeat;
    t_oneshot;
    t_timebase;
    t_disable;
    t_por;
    test_done;
  end

  // the whole sequence needs well under 5000 cycles
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    test_done;
  end
endmodule // rtc_interval_alarm_tb
`default_nettype wire
